// ===== design/regulator_fault_sequencer_pkg.sv
// package for the regulator startup and fault sequencer
// assumes a 50 MHz internal clock; all analog comparisons arrive as digital flags
package regulator_fault_sequencer_pkg;

    localparam int  CLOCK_HZ            = 50_000_000;
    localparam int  STARTUP_TIMEOUT_MS  = 50;
    localparam int  OVERCURRENT_TIMEOUT_MS = 50;
    localparam int  RESTART_DELAY_MS    = 100;
    localparam int  STARTUP_TIMEOUT_CYC = CLOCK_HZ / 1000 * STARTUP_TIMEOUT_MS;
    localparam int  OVERCURRENT_TIMEOUT_CYC = CLOCK_HZ / 1000 * OVERCURRENT_TIMEOUT_MS;
    localparam int  RESTART_DELAY_CYC   = CLOCK_HZ / 1000 * RESTART_DELAY_MS;
    localparam int  TIMER_WIDTH         = 24;
    localparam int  RAIL_COUNT          = 5;
    localparam int  FEEDBACK_COUNT      = 4;
    localparam logic [3:0] FAULT_COUNT_LIMIT = 4'h8;
    localparam logic [3:0] FAULT_COUNT_ZERO  = 4'h0;
    localparam logic [4:0] RAILS_OFF         = 5'h00;

    // rail index order is the power-up order
    localparam int  RAIL_DIGITAL  = 0;
    localparam int  RAIL_ANALOG   = 1;
    localparam int  RAIL_GATE_LOW = 2;
    localparam int  RAIL_GATE_HIGH = 3;
    localparam int  RAIL_COMMON   = 4;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_INIT,
        ST_RAIL_WAIT,
        ST_SHORT_CHECK,
        ST_DISCONNECT,
        ST_RAIL_UP,
        ST_RUN,
        ST_SEQ_DOWN,
        ST_RESTART_WAIT,
        ST_LOCKED
    } seq_state_type;

    typedef struct packed {
        logic                       inputUvlo;       // input supply below lockout
        logic                       internalUvlo;    // internal rail below lockout
        logic                       thermalLimit;    // thermal shutdown limit
        logic [FEEDBACK_COUNT-1:0]  feedbackShorted; // sense pin reads shorted
        logic                       gateLow;         // gate below input minus 3.5 V
        logic [RAIL_COUNT-1:0]      railGood;        // rail above 90 % of target
        logic [RAIL_COUNT-1:0]      railUnder;       // more than 20 % under target
        logic [RAIL_COUNT-1:0]      railOver;        // more than 20 % over target
        logic [RAIL_COUNT-1:0]      railOverCurrent; // rail at its current limit
        logic                       inputSenseTrip;  // input sense trip
        logic                       switchOverVolt;  // switch overvoltage limit
        logic                       switchOverCur;   // switch current above 150 %
    } monitor_type;

endpackage

// ===== design/regulator_fault_sequencer.sv
// startup sequencer and fault handler for a five-rail bias regulator
// assumes analog monitors are already synchronous to clock; no software registers
`timescale 1ns/1ps

module regulator_fault_sequencer
    import regulator_fault_sequencer_pkg::*;
#(
    parameter int STARTUP_CYC  = STARTUP_TIMEOUT_CYC,      // startup step timeout
    parameter int OVERCUR_CYC  = OVERCURRENT_TIMEOUT_CYC,  // overcurrent timeout
    parameter int RESTART_CYC  = RESTART_DELAY_CYC         // restart delay
) (
    input  wire logic                                     clock,           // 50 MHz
    input  wire logic                                     rst_b,           // async reset
    input  wire logic                                     enablePrimary,   // host enable 1
    input  wire logic                                     enableSecondary, // host enable 2
    input  wire regulator_fault_sequencer_pkg::monitor_type monitor,       // analog flags
    output logic [regulator_fault_sequencer_pkg::RAIL_COUNT-1:0] railOn,   // rail enables
    output logic                                          gatePullDown,    // disconnect gate
    output logic                                          shortTestOn,     // short test bias
    output logic                                          fault_b,         // fault, low active
    output logic [3:0]                                    faultCount       // fault counter
);
    import regulator_fault_sequencer_pkg::*;

    function automatic logic timerDone(input logic [TIMER_WIDTH-1:0] t, input int lim);
        timerDone = (t >= TIMER_WIDTH'(lim - 1));
    endfunction

    logic rstMeta_q;
    logic rstSync_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    seq_state_type            state_q, state_d;
    logic [TIMER_WIDTH-1:0]   timer_q, timer_d;
    logic [TIMER_WIDTH-1:0]   ocTimer_q, ocTimer_d;
    logic [2:0]               railIdx_q, railIdx_d;
    logic [RAIL_COUNT-1:0]    railOn_q, railOn_d;
    logic                     gate_q, gate_d;
    logic                     short_q, short_d;
    logic                     fault_q, fault_d;
    logic [3:0]               count_q, count_d;
    logic                     anyEnable;
    logic                     active;
    logic                     immediateFault;
    logic                     orderedFault;
    logic                     stepFault;
    logic                     countFault;

    assign anyEnable = enablePrimary | enableSecondary;
    assign active    = (state_q == ST_SHORT_CHECK) || (state_q == ST_DISCONNECT) ||
                       (state_q == ST_RAIL_UP) || (state_q == ST_RUN) ||
                       (state_q == ST_SEQ_DOWN);
    assign immediateFault = monitor.inputSenseTrip | monitor.switchOverVolt |
                            monitor.switchOverCur;
    // under/over detections are masked in startup, they only count once running
    assign orderedFault = monitor.thermalLimit |
                          ((state_q == ST_RUN) && ((|(monitor.railUnder & railOn_q)) ||
                                                   (|(monitor.railOver & railOn_q)))) |
                          timerDone(ocTimer_q, OVERCUR_CYC);
    assign stepFault  = timerDone(timer_q, STARTUP_CYC);
    // a second fault inside a counted shutdown must not carry the counter past its limit
    assign countFault = (count_q >= FAULT_COUNT_LIMIT - 4'h1);

    always_comb begin
        state_d   = state_q;
        timer_d   = timer_q + TIMER_WIDTH'(1);
        ocTimer_d = RAILS_OFF == (monitor.railOverCurrent & railOn_q) ?
                    '0 : ocTimer_q + TIMER_WIDTH'(1);
        railIdx_d = railIdx_q;
        railOn_d  = railOn_q;
        gate_d    = gate_q;
        short_d   = 1'b0;
        fault_d   = 1'b1;
        count_d   = count_q;
        if (monitor.inputUvlo || (monitor.internalUvlo && state_q != ST_OFF &&
                                  state_q != ST_INIT && state_q != ST_RAIL_WAIT)) begin
            // lockout: everything off at once, counter cleared, flag set high
            count_d  = FAULT_COUNT_ZERO;
            railOn_d = RAILS_OFF;
            gate_d   = 1'b0;
            timer_d  = '0;
            state_d  = monitor.inputUvlo ? ST_OFF : ST_RESTART_WAIT;
        end else if (active && immediateFault) begin
            railOn_d = RAILS_OFF;
            gate_d   = 1'b0;
            count_d  = countFault ? FAULT_COUNT_LIMIT : count_q + 4'h1;
            fault_d  = 1'b0;
            timer_d  = '0;
            state_d  = countFault ? ST_LOCKED : ST_RESTART_WAIT;
        end else if (active && state_q != ST_SEQ_DOWN && orderedFault) begin
            railOn_d = railOn_q & ~(monitor.railOver & {RAIL_COUNT{state_q == ST_RUN}});
            count_d  = count_q + 4'h1;
            railIdx_d = 3'(RAIL_COUNT - 1);
            timer_d  = '0;
            state_d  = ST_SEQ_DOWN;
        end else begin
            case (state_q)
                ST_OFF: begin
                    timer_d = '0;
                    if (enablePrimary) begin
                        state_d = ST_INIT;
                    end
                end
                ST_INIT: begin
                    timer_d = '0;
                    state_d = ST_RAIL_WAIT;
                end
                ST_RAIL_WAIT: begin
                    timer_d = '0;
                    if (!monitor.internalUvlo) begin
                        state_d = ST_SHORT_CHECK;
                    end
                end
                ST_SHORT_CHECK: begin
                    short_d = 1'b1;
                    if (monitor.feedbackShorted == '0) begin
                        timer_d = '0;
                        state_d = ST_DISCONNECT;
                    end else if (stepFault) begin
                        count_d = count_q + 4'h1;
                        fault_d = 1'b0;
                        timer_d = '0;
                        state_d = countFault ? ST_LOCKED : ST_RESTART_WAIT;
                    end
                end
                ST_DISCONNECT: begin
                    gate_d = 1'b1;
                    if (monitor.gateLow) begin
                        timer_d   = '0;
                        railIdx_d = 3'h0;
                        state_d   = ST_RAIL_UP;
                    end else if (stepFault) begin
                        gate_d  = 1'b0;
                        count_d = count_q + 4'h1;
                        fault_d = 1'b0;
                        timer_d = '0;
                        state_d = countFault ? ST_LOCKED : ST_RESTART_WAIT;
                    end
                end
                ST_RAIL_UP: begin
                    railOn_d[railIdx_q] = 1'b1;
                    if (railOn_q[railIdx_q] && monitor.railGood[railIdx_q]) begin
                        timer_d = '0;
                        if (railIdx_q == 3'(RAIL_COUNT - 1)) begin
                            state_d = ST_RUN;
                        end else begin
                            railIdx_d = railIdx_q + 3'h1;
                        end
                    end else if (stepFault) begin
                        railIdx_d = railIdx_q;
                        timer_d   = '0;
                        count_d   = count_q + 4'h1;
                        state_d   = ST_SEQ_DOWN;
                    end
                end
                ST_RUN: begin
                    timer_d = '0;
                    if (!anyEnable) begin
                        railIdx_d = 3'(RAIL_COUNT - 1);
                        state_d   = ST_SEQ_DOWN;
                    end
                end
                ST_SEQ_DOWN: begin
                    // reverse order, one rail per step
                    railOn_d[railIdx_q] = 1'b0;
                    if (railIdx_q == 3'h0) begin
                        gate_d  = 1'b0;
                        timer_d = '0;
                        if (count_q != FAULT_COUNT_ZERO && anyEnable) begin
                            fault_d = 1'b0;
                            state_d = (count_q == FAULT_COUNT_LIMIT) ? ST_LOCKED
                                                                     : ST_RESTART_WAIT;
                        end else if (!anyEnable) begin
                            count_d = FAULT_COUNT_ZERO;
                            state_d = ST_OFF;
                        end else begin
                            state_d = ST_OFF;
                        end
                    end else begin
                        railIdx_d = railIdx_q - 3'h1;
                    end
                end
                ST_RESTART_WAIT: begin
                    fault_d = (fault_q == 1'b0) ? 1'b0 : 1'b1;
                    if (timerDone(timer_q, RESTART_CYC)) begin
                        fault_d = 1'b1;
                        timer_d = '0;
                        state_d = ST_OFF;
                    end
                end
                ST_LOCKED: begin
                    timer_d = '0;
                    fault_d = 1'b0;
                    if (!anyEnable) begin
                        count_d = FAULT_COUNT_ZERO;
                        fault_d = 1'b1;
                        state_d = ST_OFF;
                    end
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            state_q   <= ST_OFF;
            timer_q   <= '0;
            ocTimer_q <= '0;
            railIdx_q <= 3'h0;
            railOn_q  <= RAILS_OFF;
            gate_q    <= 1'b0;
            short_q   <= 1'b0;
            fault_q   <= 1'b1;
            count_q   <= FAULT_COUNT_ZERO;
        end else begin
            state_q   <= state_d;
            timer_q   <= timer_d;
            ocTimer_q <= ocTimer_d;
            railIdx_q <= railIdx_d;
            railOn_q  <= railOn_d;
            gate_q    <= gate_d;
            short_q   <= short_d;
            fault_q   <= fault_d;
            count_q   <= count_d;
        end
    end

    assign railOn       = railOn_q;
    assign gatePullDown = gate_q;
    assign shortTestOn  = short_q;
    assign fault_b      = fault_q;
    assign faultCount   = count_q;

    property p_no_rail_before_check;
        @(posedge clock) disable iff (!rstSync_q)
        (state_q inside {ST_SHORT_CHECK, ST_DISCONNECT}) |-> railOn_q == RAILS_OFF;
    endproperty
    a_no_rail_before_check: assert property (p_no_rail_before_check)
        else $error("rail on before pre-output check finished");

    property p_lockout_no_fault;
        @(posedge clock) disable iff (!rstSync_q)
        monitor.inputUvlo |=> (fault_b && count_q == FAULT_COUNT_ZERO);
    endproperty
    a_lockout_no_fault: assert property (p_lockout_no_fault)
        else $error("lockout raised fault or kept counter");

    property p_wait_no_timeout;
        @(posedge clock) disable iff (!rstSync_q)
        (state_q == ST_RAIL_WAIT) |-> timer_q == '0;
    endproperty
    a_wait_no_timeout: assert property (p_wait_no_timeout)
        else $error("internal rail wait is timed");

    property p_rail_order;
        @(posedge clock) disable iff (!rstSync_q)
        (state_q == ST_RAIL_UP && railOn_q[RAIL_ANALOG]) |-> railOn_q[RAIL_DIGITAL];
    endproperty
    a_rail_order: assert property (p_rail_order)
        else $error("analog rail on before digital rail");

    property p_immediate_off;
        @(posedge clock) disable iff (!rstSync_q)
        (active && immediateFault && !monitor.inputUvlo && !monitor.internalUvlo)
            |=> (railOn_q == RAILS_OFF && !fault_b);
    endproperty
    a_immediate_off: assert property (p_immediate_off)
        else $error("immediate fault did not drop rails");

    property p_fault_in_wait;
        @(posedge clock) disable iff (!rstSync_q)
        !fault_b |-> state_q inside {ST_RESTART_WAIT, ST_LOCKED};
    endproperty
    a_fault_in_wait: assert property (p_fault_in_wait)
        else $error("fault output low outside restart delay");

    property p_count_cap;
        @(posedge clock) disable iff (!rstSync_q)
        count_q <= FAULT_COUNT_LIMIT;
    endproperty
    a_count_cap: assert property (p_count_cap)
        else $error("fault counter ran past its limit");

    property p_step_timer_restart;
        @(posedge clock) disable iff (!rstSync_q)
        (state_q != $past(state_q) && state_q == ST_DISCONNECT) |-> timer_q <= 1;
    endproperty
    a_step_timer_restart: assert property (p_step_timer_restart)
        else $error("step timer not restarted on entry");

    c_reach_run: cover property (@(posedge clock) disable iff (!rstSync_q)
        state_q == ST_RUN);
    c_restart: cover property (@(posedge clock) disable iff (!rstSync_q)
        state_q == ST_RESTART_WAIT && !fault_b);
    c_locked: cover property (@(posedge clock) disable iff (!rstSync_q)
        state_q == ST_LOCKED);

endmodule

// ===== verif/regulator_host_model.sv
// host model: one request drives both enables, changed at the falling clock edge
// assumes the bench owns the request and reads the fault output itself
`timescale 1ns/1ps
module regulator_host_model (
    input  wire logic clock,           // system clock
    input  wire logic hostOn,          // bench request to run
    output logic      enablePrimary,   // enable 1
    output logic      enableSecondary  // enable 2
);
    logic request_q = 1'h0;
    // the request is taken on the rising edge so falling-edge bench writes never race it
    always @(posedge clock) begin
        request_q <= hostOn;
    end
    // both enables move together, so every stop is a full clearing shutdown
    always @(negedge clock) begin
        enablePrimary <= request_q;
        enableSecondary <= request_q;
    end
endmodule

// ===== verif/regulator_fault_sequencer_tb.sv
// bench for the regulator sequencer: fault table, lockout and startup checks
// assumes a plant that reports a rail good half a cycle after it is enabled
`timescale 1ns/1ps
module regulator_fault_sequencer_tb;
    import regulator_fault_sequencer_pkg::*;
    localparam int SU = 20;
    localparam int OC = 20;
    localparam int RS = 40;
    localparam int RUN = 0, OFF = 1, FLT = 2, CLR = 3, SHT = 4, GTE = 5;
    typedef struct {int k; int lim; logic f; logic [3:0] c; logic ord;} row_type;
    row_type     rows [8] = '{'{0, 12, 1'h1, 4'h1, 1'h1}, '{1, 12, 1'h1, 4'h2, 1'h1},
        '{2, 12, 1'h1, 4'h3, 1'h0}, '{3, 40, 1'h1, 4'h4, 1'h1}, '{4, 3, 1'h1, 4'h5, 1'h0},
        '{5, 3, 1'h1, 4'h6, 1'h0}, '{6, 3, 1'h1, 4'h7, 1'h0}, '{7, 3, 1'h0, 4'h0, 1'h0}};
    logic        clock = 1'h0;
    logic        rst_b = 1'h0;
    logic        hostOn = 1'h0;
    logic        gateOk = 1'h1;
    logic        ordered = 1'h1;
    logic [4:0]  stuck = 5'h00;
    logic [4:0]  prevRail = 5'h00;
    monitor_type mon = '0;
    monitor_type monitor = '0;
    logic        enablePrimary, enableSecondary, gatePullDown, shortTestOn, fault_b;
    logic [4:0]  railOn;
    logic [3:0]  faultCount;
    int          fails = 0, compares = 0, waited = 0, cycles = 0;

    regulator_fault_sequencer #(.STARTUP_CYC(SU), .OVERCUR_CYC(OC), .RESTART_CYC(RS))
        regulator_fault_sequencer_i (.clock(clock), .rst_b(rst_b),
        .enablePrimary(enablePrimary), .enableSecondary(enableSecondary),
        .monitor(monitor), .railOn(railOn), .gatePullDown(gatePullDown),
        .shortTestOn(shortTestOn), .fault_b(fault_b), .faultCount(faultCount));
    regulator_host_model regulator_host_model_i (.clock(clock), .hostOn(hostOn),
        .enablePrimary(enablePrimary), .enableSecondary(enableSecondary));

    always #10 clock = ~clock;

    function automatic monitor_type plant();
        monitor_type m;
        m = mon;
        m.railGood = railOn & ~stuck;
        m.gateLow = gatePullDown & gateOk;
        return m;
    endfunction

    // the 1 ns step lets bench changes made at the same falling edge land first
    always @(negedge clock) begin
        #1;
        monitor <= plant();
    end

    function automatic logic cond(input int w);
        case (w)
            RUN: return railOn === 5'h1F;
            OFF: return railOn === 5'h00;
            FLT: return fault_b === 1'h0;
            CLR: return fault_b === 1'h1;
            SHT: return shortTestOn === 1'h1;
            default: return gatePullDown === 1'h1;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    // ordered moves add or remove one rail at the end of the power-up order;
    // sampled on the falling edge, where the rail enables have settled
    always @(negedge clock) begin
        prevRail <= railOn;
        if (ordered && railOn !== prevRail) begin
            check("order", {7'h00, ((railOn & (railOn + 5'h01)) == 5'h00)
                && ($countones(railOn ^ prevRail) == 1)}, 8'h01);
        end
    end

    task automatic waitUntil(input int w, input int lim);
        waited = 0;
        while (!cond(w) && waited < lim) begin
            @(negedge clock);
            waited++;
        end
        check("wait", {7'h00, cond(w)}, 8'h01);
    endtask

    task automatic setFault(input int k, input logic v);
        case (k)
            0: mon.thermalLimit = v;
            1: mon.railUnder[1] = v;
            2: mon.railOver[3] = v;
            3: mon.railOverCurrent[0] = v;
            4: mon.inputSenseTrip = v;
            5: mon.switchOverVolt = v;
            6: mon.switchOverCur = v;
            7: mon.internalUvlo = v;
            default: mon.inputUvlo = v;
        endcase
    endtask

    task automatic bringUp();
        hostOn = 1'h1;
        waitUntil(SHT, RS + 60);
        check("rails early", {3'h0, railOn}, 8'h00);
        waitUntil(GTE, 30);
        check("rails early", {3'h0, railOn}, 8'h00);
        waitUntil(RUN, 30);
    endtask

    task automatic stuckStart(input int k);
        hostOn = 1'h0;
        waitUntil(OFF, 40);
        repeat (3) @(negedge clock);
        mon.feedbackShorted = (k < 2) ? 4'h8 : 4'h0;
        gateOk = (k != 1);
        stuck = (k == 2) ? 5'h04 : 5'h00;
        hostOn = 1'h1;
        waitUntil(SHT, 10);
        if (k == 1) begin
            // a short that clears late must not eat into the next step's time
            repeat (SU - 5) @(negedge clock);
            mon.feedbackShorted = 4'h0;
        end
        if (k > 0) begin
            waitUntil(GTE, 10);
        end
        waitUntil(FLT, SU + 40);
        if (k < 2) begin
            check("timeout", {7'h0, waited >= SU - 3 && waited <= SU + 3}, 8'h01);
        end
        check("fault count", {4'h0, faultCount}, 8'h01);
        check("rails off", {3'h0, railOn}, 8'h00);
        mon.feedbackShorted = 4'h0;
        gateOk = 1'h1;
        stuck = 5'h00;
        waitUntil(RUN, RS + 80);
    endtask

    initial begin
        repeat (5) @(negedge clock);
        check("reset rails", {2'h0, railOn, shortTestOn}, 8'h00);
        check("reset flags", {6'h0, fault_b, gatePullDown}, 8'h02);
        check("reset count", {4'h0, faultCount}, 8'h00);
        repeat (5) @(negedge clock);
        rst_b = 1'h1;
        repeat (3) @(negedge clock);
        // counts climb across rows on purpose; the lockout row then clears them
        for (int r = 0; r < 8; r++) begin
            bringUp();
            if (rows[r].k == 3) begin
                setFault(3, 1'h1);
                repeat (OC / 2) @(negedge clock);
                setFault(3, 1'h0);
                repeat (4) @(negedge clock);
                check("brief overcurrent", {3'h0, railOn}, 8'h1F);
            end
            ordered = rows[r].ord;
            setFault(rows[r].k, 1'h1);
            waitUntil(OFF, rows[r].lim);
            setFault(rows[r].k, 1'h0);
            repeat (3) @(negedge clock);
            ordered = 1'h1;
            check("count", {4'h0, faultCount}, {4'h0, rows[r].c});
            check("flag", {7'h0, fault_b}, {7'h0, ~rows[r].f});
            waited = 0;
            while (fault_b === 1'h0 && waited < RS + 10) begin
                @(negedge clock);
                waited++;
            end
            check("delay", {7'h0, rows[r].f ? (waited >= RS - 8 && waited <= RS)
                : waited == 0}, 8'h01);
        end
        for (int i = 0; i < 8; i++) begin
            bringUp();
            ordered = 1'h0;
            setFault(6, 1'h1);
            waitUntil(OFF, 3);
            setFault(6, 1'h0);
            // let the order monitor pass the unordered drop before it is armed again
            @(negedge clock);
            ordered = 1'h1;
        end
        repeat (RS + 20) @(negedge clock);
        check("locked count", {4'h0, faultCount}, 8'h08);
        check("locked state", {1'h0, railOn, shortTestOn, fault_b}, 8'h00);
        hostOn = 1'h0;
        waitUntil(CLR, 10);
        check("cleared count", {4'h0, faultCount}, 8'h00);
        setFault(8, 1'h1);
        hostOn = 1'h1;
        repeat (SU * 2) @(negedge clock);
        check("undervoltage_lockout wait", {2'h0, railOn, shortTestOn}, 8'h00);
        check("undervoltage_lockout flag", {7'h0, fault_b}, 8'h01);
        setFault(8, 1'h0);
        bringUp();
        ordered = 1'h0;
        setFault(6, 1'h1);
        waitUntil(OFF, 3);
        setFault(6, 1'h0);
        bringUp();
        setFault(8, 1'h1);
        waitUntil(OFF, 3);
        repeat (2) @(negedge clock);
        check("undervoltage_lockout count", {4'h0, faultCount}, 8'h00);
        check("undervoltage_lockout flag", {7'h0, fault_b}, 8'h01);
        hostOn = 1'h0;
        ordered = 1'h1;
        // hold the lockout until the enables have fallen, or the sequencer restarts early
        repeat (3) @(negedge clock);
        setFault(8, 1'h0);
        setFault(7, 1'h1);
        hostOn = 1'h1;
        repeat (SU * 3) @(negedge clock);
        check("bias wait", {2'h0, railOn, shortTestOn}, 8'h00);
        check("bias flag", {7'h0, fault_b}, 8'h01);
        setFault(7, 1'h0);
        waitUntil(RUN, 40);
        for (int k = 0; k < 3; k++) begin
            stuckStart(k);
        end
        end_of_test();
    end
endmodule
